// >>> rtl/tmr_core.sv
// 8/16-bit timer/counter core with a classic wishbone slave.
// assumes capture_trig and irq_ack are one-cycle pulses
// synchronous to clk_sys.
`timescale 1ns/1ps
module tmr_core (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // wishbone slave
  input  tmr_pkg::tmr_wb_req_t wb_req,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  // timer pins and events
  input  wire logic            ext_count_pin,
  input  wire logic            capture_trig,
  // interrupt requests and service acknowledge
  input  wire logic [3:0]      irq_ack,
  output logic [3:0]           irq_req
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tmr_pkg::tmr_ctl_t ctl;
    logic [2:0]        clock_select;
    logic [7:0]        cnt_lo;
    logic [7:0]        cnt_hi;
    logic [7:0]        cmp_a;
    logic [7:0]        cmp_b;
    logic [3:0]        flags;
    logic [3:0]        mask;
    logic              blk;
    logic              ack;
    logic [31:0]       rdat;
    logic [3:0]        irq;
  } tmr_st_t;

  tmr_st_t s_q;
  tmr_st_t s_d;

  logic        timer_tick;
  logic        at_max;
  logic        hit_a;
  logic        hit_b;
  logic        ctc_hit;
  logic        acc;
  logic        wr;
  logic        wr_cnt;
  logic [7:0]  wdat;
  logic [31:0] rd_mux;
  logic [3:0]  set;
  logic [3:0]  clr;
  logic [15:0] cnt16;

  // ****************************************
  // submodules
  // ****************************************
  tmr_clksel u_clksel (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .clock_select (s_q.clock_select),
    .ext_count_pin(ext_count_pin),
    .timer_tick   (timer_tick)
  );

  tmr_cmp u_cmp (
    .count_low_byte (s_q.cnt_lo),
    .count_high_byte(s_q.cnt_hi),
    .compare_value_a(s_q.cmp_a),
    .compare_value_b(s_q.cmp_b),
    .ctl            (s_q.ctl),
    .at_max         (at_max),
    .hit_a          (hit_a),
    .hit_b          (hit_b),
    .ctc_hit        (ctc_hit)
  );

  // ****************************************
  // bus decode
  // ****************************************
  // ack one cycle after the request; write commits on the ack edge
  assign acc    = wb_req.cyc & wb_req.stb;
  assign wr     = acc & s_q.ack & wb_req.we & wb_req.sel[0];
  assign wdat   = wb_req.dat[7:0];
  assign wr_cnt = wr & ((wb_req.adr == tmr_pkg::ADR_CNT_LO)
                     | (wb_req.adr == tmr_pkg::ADR_CNT_HI));
  assign cnt16  = {s_q.cnt_hi, s_q.cnt_lo};

  always_comb begin
    rd_mux = '0;
    unique case (wb_req.adr)
      tmr_pkg::ADR_CTL_A:  rd_mux[2:0] = s_q.ctl;
      tmr_pkg::ADR_CTL_B:  rd_mux[2:0] = s_q.clock_select;
      tmr_pkg::ADR_CNT_LO: rd_mux[7:0] = s_q.cnt_lo;
      tmr_pkg::ADR_CNT_HI: rd_mux[7:0] = s_q.cnt_hi;
      tmr_pkg::ADR_CMP_A:  rd_mux[7:0] = s_q.cmp_a;
      tmr_pkg::ADR_CMP_B:  rd_mux[7:0] = s_q.cmp_b;
      tmr_pkg::ADR_FLAGS:  rd_mux[3:0] = s_q.flags;
      tmr_pkg::ADR_MASK:   rd_mux[3:0] = s_q.mask;
      default:             rd_mux = '0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d      = s_q;
    set      = '0;
    clr      = irq_ack;
    s_d.ack  = acc & ~s_q.ack;
    if (acc & ~s_q.ack) begin
      s_d.rdat = rd_mux;
    end
    // counting; the comparator looks at the value before the tick
    if (timer_tick) begin
      if (ctc_hit) begin
        s_d.cnt_lo = tmr_pkg::ZERO8;
      end else if (s_q.ctl.width) begin
        {s_d.cnt_hi, s_d.cnt_lo} = cnt16 + tmr_pkg::ONE16;
      end else begin
        s_d.cnt_lo = s_q.cnt_lo + tmr_pkg::ONE8;
      end
      set[tmr_pkg::FLG_OVF] = at_max;
      if (!s_q.blk) begin
        set[tmr_pkg::FLG_MA] = hit_a;
        set[tmr_pkg::FLG_MB] = hit_b;
      end
      s_d.blk = 1'b0;
    end
    // register writes
    if (wr) begin
      unique case (wb_req.adr)
        tmr_pkg::ADR_CTL_A: begin
          s_d.ctl = tmr_pkg::tmr_ctl_t'(wdat[2:0]);
        end
        tmr_pkg::ADR_CTL_B: s_d.clock_select = wdat[2:0];
        tmr_pkg::ADR_CNT_LO: s_d.cnt_lo = wdat;
        tmr_pkg::ADR_CNT_HI: s_d.cnt_hi = wdat;
        tmr_pkg::ADR_CMP_A: s_d.cmp_a = wdat;
        tmr_pkg::ADR_CMP_B: s_d.cmp_b = wdat;
        tmr_pkg::ADR_FLAGS: clr = clr | wdat[3:0];
        tmr_pkg::ADR_MASK: s_d.mask = wdat[3:0];
        default: s_d.blk = s_d.blk;
      endcase
    end
    if (wr_cnt) begin
      s_d.blk = 1'b1;
    end
    // capture overrides a same-cycle compare write
    if (capture_trig & s_q.ctl.cap_en) begin
      s_d.cmp_a = s_q.cnt_lo;
      if (s_q.ctl.width) begin
        s_d.cmp_b = s_q.cnt_hi;
      end
      set[tmr_pkg::FLG_CAP] = 1'b1;
    end
    // a set in the clearing cycle wins
    s_d.flags = (s_q.flags & ~clr) | set;
    s_d.irq   = s_d.flags & s_d.mask;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign irq_req  = s_q.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_stop_no_tick: assert property (
    (s_q.clock_select == tmr_pkg::CS_STOP) [*2] |-> !timer_tick)
    else $error("tick while stopped");

  a_count_inc: assert property (
    timer_tick && !wr && !s_q.ctl.width && !ctc_hit
    |=> s_q.cnt_lo == $past(s_q.cnt_lo) + 8'h01)
    else $error("8-bit count did not step");

  a_wide_inc: assert property (
    timer_tick && !wr && s_q.ctl.width
    |=> {s_q.cnt_hi, s_q.cnt_lo} == $past(cnt16) + 16'h0001)
    else $error("16-bit count did not step");

  a_write_prio: assert property (
    wr && wb_req.adr == tmr_pkg::ADR_CNT_LO
    |=> s_q.cnt_lo == $past(wdat) && s_q.blk)
    else $error("counter write lost");

  a_ovf_wrap: assert property (
    timer_tick && at_max && !wr && !s_q.ctl.width
    |=> s_q.cnt_lo == 8'h00 && s_q.flags[tmr_pkg::FLG_OVF])
    else $error("overflow not set on wrap");

  a_ovf_sticky: assert property (
    s_q.flags[tmr_pkg::FLG_OVF] && !irq_ack[tmr_pkg::FLG_OVF] && !wr
    |=> s_q.flags[tmr_pkg::FLG_OVF])
    else $error("overflow cleared by hardware");

  a_ctc_clear: assert property (
    timer_tick && ctc_hit && !wr && !s_q.blk
    |=> s_q.cnt_lo == 8'h00 && s_q.flags[tmr_pkg::FLG_MA])
    else $error("clear on match failed");

  a_match_block: assert property (
    s_q.blk && timer_tick && !s_q.flags[tmr_pkg::FLG_MB]
    && !capture_trig |=> !s_q.flags[tmr_pkg::FLG_MB])
    else $error("match not blocked after write");

  a_wide_no_b: assert property (
    s_q.ctl.width && !wr && !s_q.flags[tmr_pkg::FLG_MB]
    |=> !s_q.flags[tmr_pkg::FLG_MB])
    else $error("match b set in 16-bit mode");

  a_cap_copy: assert property (
    capture_trig && s_q.ctl.cap_en
    |=> s_q.cmp_a == $past(s_q.cnt_lo) && s_q.flags[tmr_pkg::FLG_CAP])
    else $error("capture not taken");

  a_irq_mask: assert property (
    ##1 irq_req == (s_q.flags & s_q.mask))
    else $error("irq request differs from flags and mask");

  a_ack_answer: assert property (
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  a_read_count: assert property (
    wb_req.cyc && wb_req.stb && !wb_ack_o
    && wb_req.adr == tmr_pkg::ADR_CNT_LO
    |=> wb_dat_o[7:0] == $past(s_q.cnt_lo))
    else $error("counter read data wrong");

  a_stop_hold: assert property (
    (s_q.clock_select == tmr_pkg::CS_STOP) [*2] ##0 !wr
    |=> $stable(s_q.cnt_lo) && $stable(s_q.cnt_hi))
    else $error("counter moved while stopped");

  a_div1_tick: assert property (
    (s_q.clock_select == tmr_pkg::CS_DIV1) [*2] |-> timer_tick)
    else $error("no tick at full rate");

  a_pin_rise: assert property (
    (s_q.clock_select == tmr_pkg::CS_EXT_RISE) [*2]
    ##0 $rose(ext_count_pin) |=> timer_tick)
    else $error("rising pin edge gave no tick");

  a_pin_fall: assert property (
    (s_q.clock_select == tmr_pkg::CS_EXT_FALL) [*2]
    ##0 $fell(ext_count_pin) |=> timer_tick)
    else $error("falling pin edge gave no tick");

  a_wide_wrap: assert property (
    timer_tick && at_max && !wr && s_q.ctl.width
    |=> {s_q.cnt_hi, s_q.cnt_lo} == '0 && s_q.flags[tmr_pkg::FLG_OVF])
    else $error("16-bit wrap or overflow wrong");

  a_hi_hold: assert property (
    timer_tick && !wr && !s_q.ctl.width |=> $stable(s_q.cnt_hi))
    else $error("high byte moved in 8-bit mode");

  a_ctc_ovf: assert property (
    timer_tick && at_max && s_q.ctl.ctc && !wr
    |=> s_q.flags[tmr_pkg::FLG_OVF])
    else $error("overflow missed in clear-on-match mode");

  a_match_b8: assert property (
    timer_tick && !s_q.blk && !s_q.ctl.width
    && s_q.cnt_lo == s_q.cmp_b |=> s_q.flags[tmr_pkg::FLG_MB])
    else $error("match b not flagged");

  a_blk_once: assert property (
    s_q.blk && timer_tick && !wr_cnt |=> !s_q.blk)
    else $error("match block outlived one tick");

  a_set_wins: assert property (
    timer_tick && at_max && irq_ack[tmr_pkg::FLG_OVF]
    |=> s_q.flags[tmr_pkg::FLG_OVF])
    else $error("clear beat a same-cycle overflow");

  a_ack_clears: assert property (
    s_q.flags[tmr_pkg::FLG_OVF] && irq_ack[tmr_pkg::FLG_OVF]
    && !(timer_tick && at_max) |=> !s_q.flags[tmr_pkg::FLG_OVF])
    else $error("service acknowledge did not clear");

  a_one_clears: assert property (
    wr && wb_req.adr == tmr_pkg::ADR_FLAGS && wdat[tmr_pkg::FLG_MB]
    && !(timer_tick && hit_b && !s_q.blk)
    |=> !s_q.flags[tmr_pkg::FLG_MB])
    else $error("written one did not clear");

  a_cmp_direct: assert property (
    wr && wb_req.adr == tmr_pkg::ADR_CMP_A && !s_q.ctl.cap_en
    |=> s_q.cmp_a == $past(wdat))
    else $error("compare write not immediate");

  a_cap_high: assert property (
    capture_trig && s_q.ctl.cap_en && s_q.ctl.width
    |=> s_q.cmp_b == $past(s_q.cnt_hi))
    else $error("high byte not captured");

  a_cap_no_match: assert property (
    s_q.ctl.cap_en && s_q.ctl.width && !s_q.flags[tmr_pkg::FLG_MA]
    |=> !s_q.flags[tmr_pkg::FLG_MA])
    else $error("match a set in 16-bit capture");

endmodule : tmr_core

// >>> include/tmr_pkg.sv
// package of the timer/counter core: register map, field
// positions, limits, clock select codes and carrier structs.
// assumes a 32-bit classic wishbone slave port, byte offsets.
package tmr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADR_CTL_A  = 8'h00;
  localparam logic [7:0] ADR_CTL_B  = 8'h04;
  localparam logic [7:0] ADR_CNT_LO = 8'h08;
  localparam logic [7:0] ADR_CNT_HI = 8'h0c;
  localparam logic [7:0] ADR_CMP_A  = 8'h10;
  localparam logic [7:0] ADR_CMP_B  = 8'h14;
  localparam logic [7:0] ADR_FLAGS  = 8'h18;
  localparam logic [7:0] ADR_MASK   = 8'h1c;

  // ****************************************
  // field positions and limits
  // ****************************************
  localparam int FLG_OVF = 0;
  localparam int FLG_MA  = 1;
  localparam int FLG_MB  = 2;
  localparam int FLG_CAP = 3;
  localparam int NFLAG   = 4;
  localparam logic [7:0]  MAX8   = 8'hff;
  localparam logic [15:0] MAX16  = 16'hffff;
  localparam logic [7:0]  ZERO8  = 8'h00;
  localparam logic [7:0]  ONE8   = 8'h01;
  localparam logic [15:0] ONE16  = 16'h0001;

  // ****************************************
  // clock select codes and prescaler taps
  // ****************************************
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] TAP8    = 10'h007;
  localparam logic [9:0] TAP64   = 10'h03f;
  localparam logic [9:0] TAP256  = 10'h0ff;
  localparam logic [9:0] TAP1024 = 10'h3ff;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        cap_en;
    logic        width;
    logic        ctc;
  } tmr_ctl_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } tmr_wb_req_t;

endpackage : tmr_pkg

// >>> rtl/tmr_clksel.sv
// clock select and free running prescaler; emits the timer tick.
// assumes ext_count_pin is already synchronous to clk_sys.
`timescale 1ns/1ps
module tmr_clksel (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // selection
  input  wire logic [2:0] clock_select,
  input  wire logic       ext_count_pin,
  // count enable
  output logic            timer_tick
);

  typedef struct packed {
    logic [9:0] psc;
    logic       pin;
    logic       tick;
  } tmr_cs_st_t;

  tmr_cs_st_t s_q;
  tmr_cs_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.psc  = s_q.psc + 10'h001;
    s_d.pin  = ext_count_pin;
    // prescaler runs free whatever the selection
    unique case (clock_select)
      tmr_pkg::CS_STOP:     s_d.tick = 1'b0;
      tmr_pkg::CS_DIV1:     s_d.tick = 1'b1;
      tmr_pkg::CS_DIV8:     s_d.tick = (s_q.psc[2:0] == tmr_pkg::TAP8[2:0]);
      tmr_pkg::CS_DIV64:    s_d.tick = (s_q.psc[5:0] == tmr_pkg::TAP64[5:0]);
      tmr_pkg::CS_DIV256:   s_d.tick = (s_q.psc[7:0] == tmr_pkg::TAP256[7:0]);
      tmr_pkg::CS_DIV1024:  s_d.tick = (s_q.psc == tmr_pkg::TAP1024);
      tmr_pkg::CS_EXT_FALL: s_d.tick = s_q.pin & ~ext_count_pin;
      tmr_pkg::CS_EXT_RISE: s_d.tick = ~s_q.pin & ext_count_pin;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_tick = s_q.tick;

endmodule : tmr_clksel

// >>> rtl/tmr_cmp.sv
// comparator: counter against compare values and MAX.
// purely combinational; the core samples it on each tick.
`timescale 1ns/1ps
module tmr_cmp (
  // counter and compare values
  input  wire logic [7:0]   count_low_byte,
  input  wire logic [7:0]   count_high_byte,
  input  wire logic [7:0]   compare_value_a,
  input  wire logic [7:0]   compare_value_b,
  input  tmr_pkg::tmr_ctl_t ctl,
  // results
  output logic              at_max,
  output logic              hit_a,
  output logic              hit_b,
  output logic              ctc_hit
);

  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic        cmp_on;

  assign cnt16 = {count_high_byte, count_low_byte};
  assign cmp16 = {compare_value_b, compare_value_a};
  // 16-bit capture holds captures in both compare bytes
  assign cmp_on = ~(ctl.cap_en & ctl.width);
  assign at_max = ctl.width ? (cnt16 == tmr_pkg::MAX16)
                            : (count_low_byte == tmr_pkg::MAX8);
  assign hit_a = cmp_on & (ctl.width ? (cnt16 == cmp16)
                 : (count_low_byte == compare_value_a));
  assign hit_b = ~ctl.width & (count_low_byte == compare_value_b);
  assign ctc_hit = ~ctl.cap_en & ~ctl.width & ctl.ctc
                   & (count_low_byte == compare_value_a);

endmodule : tmr_cmp

// >>> verification/tmr_core_tb.sv
// self-checking bench of the timer/counter core: bus, pin, capture.
// assumes tmr_pkg compiled first; bus reads checked through a queue.
`timescale 1ns/1ps
module tmr_core_tb;
  logic                 clk_sys;
  logic                 rst_n;
  tmr_pkg::tmr_wb_req_t wb_req;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 ext_count_pin;
  logic                 capture_trig;
  logic [3:0]           irq_ack;
  logic [3:0]           irq_req;
  logic [39:0]          exp_q[$];
  logic [39:0]          mon_e;
  logic [31:0]          rnd;
  int                   err_count;
  int                   compares;
  int                   dv[8] = '{0, 1, 8, 64, 256, 1024, 0, 0};

  tmr_core dut_u (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .wb_req       (wb_req),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .ext_count_pin(ext_count_pin),
    .capture_trig (capture_trig),
    .irq_ack      (irq_ack),
    .irq_req      (irq_req)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // one classic cycle; the slave's answer time is not assumed
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, we, s, a, {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, 24'h0, e});
    wb(a, 1'b0, 8'h00, 4'hf);
  endtask : rd

  // pin half periods of at least 3 cycles keep the edge detector honest
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_count_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_count_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : pulse

  task automatic strobe(input logic cap, input logic [3:0] ack);
    @(posedge clk_sys);
    capture_trig <= cap;
    irq_ack      <= ack;
    @(posedge clk_sys);
    capture_trig <= 1'b0;
    irq_ack      <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask : strobe

  task automatic irq_is(input logic [3:0] e);
    repeat (2) @(posedge clk_sys);
    check("irq_req", {28'h0, irq_req}, {28'h0, e});
  endtask : irq_is

  // ****************************************
  // read data monitor
  // ****************************************
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      check($sformatf("reg_%h", mon_e[39:32]), wb_dat_o,
            mon_e[31:0]);
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    int i;
    rst_n         = 1'b0;
    wb_req        = '0;
    ext_count_pin = 1'b0;
    capture_trig  = 1'b0;
    irq_ack       = 4'h0;
    rnd           = 32'h009c33d9;
    err_count     = 0;
    compares      = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) rd(8'(i * 4), 8'h00);
    irq_is(4'h0);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(8'h08 + 8'(i * 4), rnd[7:0]);
      wb(8'h08 + 8'(i * 4), 1'b1, ~rnd[7:0], 4'h0);
      rd(8'h08 + 8'(i * 4), rnd[7:0]);
    end
    $display("register access done");
    wr(8'h10, 8'h80);
    wr(8'h14, 8'h80);
    wr(8'h00, 8'h00);
    for (i = 1; i < 8; i++) begin
      wr(8'h08, 8'hff);
      wr(8'h18, 8'h0f);
      wr(8'h04, 8'(i));
      if (i >= 6) pulse(1);
      else repeat (dv[i] + 8) @(posedge clk_sys);
      wr(8'h04, 8'h00);
      rd(8'h18, 8'h01);
    end
    $display("clock select done");
    wr(8'h14, 8'h10);
    wr(8'h08, 8'h0f);
    wr(8'h18, 8'h0f);
    wr(8'h04, 8'h07);
    pulse(2);
    rd(8'h08, 8'h11);
    rd(8'h18, 8'h04);
    wr(8'h18, 8'h04);
    wr(8'h08, 8'h10);
    pulse(1);
    rd(8'h18, 8'h00);
    wr(8'h08, 8'hfe);
    pulse(3);
    rd(8'h08, 8'h01);
    rd(8'h18, 8'h01);
    irq_is(4'h0);
    wr(8'h1c, 8'h01);
    irq_is(4'h1);
    strobe(1'b0, 4'h1);
    irq_is(4'h0);
    rd(8'h18, 8'h00);
    $display("normal mode done");
    wr(8'h00, 8'h01);
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h04);
    wr(8'h08, 8'h00);
    wr(8'h18, 8'h0f);
    pulse(4);
    rd(8'h08, 8'h00);
    rd(8'h18, 8'h02);
    wr(8'h04, 8'h00);
    pulse(3);
    rd(8'h08, 8'h00);
    wr(8'h04, 8'h07);
    wr(8'h08, 8'h05);
    wr(8'h10, 8'h02);
    wr(8'h18, 8'h0f);
    pulse(251);
    rd(8'h08, 8'h00);
    rd(8'h18, 8'h01);
    pulse(3);
    rd(8'h18, 8'h03);
    $display("clear on match done");
    wr(8'h00, 8'h03);
    wr(8'h0c, 8'hff);
    wr(8'h08, 8'hfe);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h0f);
    pulse(2);
    rd(8'h0c, 8'h00);
    rd(8'h18, 8'h01);
    wr(8'h18, 8'h0f);
    pulse(3);
    rd(8'h08, 8'h03);
    rd(8'h18, 8'h02);
    $display("wide mode done");
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h33);
    wr(8'h18, 8'h0f);
    wr(8'h1c, 8'h08);
    strobe(1'b1, 4'h0);
    rd(8'h10, 8'h33);
    irq_is(4'h8);
    strobe(1'b0, 4'h8);
    irq_is(4'h0);
    wr(8'h00, 8'h06);
    wr(8'h0c, 8'h12);
    strobe(1'b1, 4'h0);
    rd(8'h14, 8'h12);
    rd(8'h10, 8'h33);
    $display("capture done");
    // reset again in mid-run, with compare and flags loaded
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h10, 8'h00);
    rd(8'h00, 8'h00);
    irq_is(4'h0);
    $display("mid-run reset done");
    repeat (4) @(posedge clk_sys);
    check("pending", 32'(exp_q.size()), 32'h0);
    report_and_stop();
  end

endmodule : tmr_core_tb
